// ### hdl/rtcio_pkg.sv
// Purpose: Shared constants for the real time clock interrupt output block
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes:   Temperature and backup words sit at four times their index
package rtcio_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned RETURN_TIME_US = 7800;  // Auto release time, 7.8 ms
   localparam int unsigned RETURN_CYCLES  =
      (RETURN_TIME_US * (CLK_HZ / 1_000_000));     // Rounds down, longest time
   localparam int unsigned CNT_W          = 21;

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_FLAGS   = 8'h00;    // Event flags
   localparam logic [7:0] ADDR_CONTROL = 8'h04;    // Enables and clock reset
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;    // Sticky status, read clears
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h0c;    // Interrupt mask
   localparam logic [7:0] IDX_TEMP     = 8'h17;    // Temperature reading index
   localparam logic [7:0] IDX_BACKUP   = 8'h18;    // Backup supply setup index
   localparam logic [7:0] ADDR_TEMP_W  = {IDX_TEMP[5:0], 2'b00};   // Index times four
   localparam logic [7:0] ADDR_BACKUP  = {IDX_BACKUP[5:0], 2'b00}; // Index times four

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned BIT_UPDATE   = 5;
   localparam int unsigned BIT_PERIODIC = 4;
   localparam int unsigned BIT_ALARM    = 3;
   localparam int unsigned BIT_RESET    = 0;
   localparam logic [7:0]  FLAG_MASK    = 8'h38;
   localparam logic [7:0]  CTRL_MASK    = 8'h39;
   localparam logic [7:0]  BACKUP_MASK  = 8'h0f;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] BACKUP_RST  = 8'h00;
   localparam logic [2:0] MASK_RST    = 3'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rtcio_pkg

// ### hdl/rtcio_pulse.sv
// Purpose: One gated interrupt source with optional auto release
// Assumes: Event is a one-cycle pulse
// Notes:   Enable low releases at once
`timescale 1ns/1ps
module rtcio_pulse #(
   parameter bit AUTO_RELEASE = 1'b1
) (
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   input  wire logic i_event,
   input  wire logic i_enable,
   input  wire logic i_flag,
   output logic      o_active
);

   logic [rtcio_pkg::CNT_W-1:0] count_reg;
   logic                        active_reg;

   // Drive on event, drop on disable, timeout or flag clear
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         active_reg <= 1'b0;
         count_reg  <= '0;
      end else if (i_event && i_enable) begin
         active_reg <= 1'b1;
         count_reg  <= rtcio_pkg::CNT_W'(rtcio_pkg::RETURN_CYCLES - 1);
      end else if (!i_enable) begin
         active_reg <= 1'b0;
      end else if (AUTO_RELEASE && active_reg) begin
         if (count_reg == '0) begin
            active_reg <= 1'b0;
         end else begin
            count_reg <= count_reg - 1'b1;
         end
      end else if (!AUTO_RELEASE && !i_flag) begin
         active_reg <= 1'b0;
      end
   end

   assign o_active = active_reg & i_enable;

   // Auto release once the count runs out
   auto_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      AUTO_RELEASE && active_reg && (count_reg == '0) && i_enable && !i_event |=> !active_reg)
      else $error("pin not released after timeout");

endmodule : rtcio_pulse

// ### hdl/rtcio_top.sv
// Purpose: Interrupt output control of a real time clock
// Assumes: Event inputs are one-cycle pulses synchronous to i_clk_sys
// Notes:   AXI4-Lite slave, open-drain interrupt pin as drive enable
//
// How it works
// - An update event with its enable set pulls the interrupt pin low.
// - A source whose enable is clear never drives the pin and clearing it releases at once.
// - An update-driven low is released by itself 7.8 ms after the event.
// - A periodic event with its enable set pulls the interrupt pin low.
// - A periodic-driven low is released by itself within 7.8 ms.
// - An alarm event with its enable set pulls the interrupt pin low.
// - An alarm-driven low stays until its flag or its enable is cleared.
// - The pin is low whenever any of the three gated sources is active.
// - Write-protected bits ignore writes and read as zero.
// - Writing one to the clock reset bit clears sub-seconds and stops the clock.
// - The clock reset is released when chip enable goes low after it was set.
// - The temperature reading at 0x17 shows raw data refreshed at each compensation.
// - The backup setup at 0x18 reads zero in bits 7 to 4 and holds four control bits.
// - Each flag is set by its event and held until zero is written; writing one does nothing.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module rtcio_top (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Events and device side
   input  wire logic        i_update_event,
   input  wire logic        i_periodic_event,
   input  wire logic        i_alarm_event,
   input  wire logic        i_chip_enable,
   input  wire logic        i_temp_valid,
   input  wire logic [7:0]  i_temp_data,
   output logic             o_clock_hold,
   output logic             o_supply_monitor_disable,
   output logic             o_backflow_switch_disable,
   output logic [1:0]       o_backup_sample_time,
   // Open-drain interrupt pin and system interrupt
   output logic             o_int_out,
   output logic             o_int_oe,
   output logic             o_irq
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0]  control_reg;
   logic [7:0]  backup_reg;
   logic [7:0]  temp_reg;
   logic        update_flag;
   logic        periodic_flag;
   logic        alarm_flag;
   logic [2:0]  irq_status_reg;
   logic [2:0]  irq_mask_reg;
   logic        ce_prev_reg;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        do_write;
   logic        do_read;
   logic        wr_lane0;
   logic        wr_flags;
   logic        wr_control;
   logic        rd_status;
   logic        update_act;
   logic        periodic_act;
   logic        alarm_act;
   logic        update_irq_enable;
   logic        periodic_irq_enable;
   logic        alarm_irq_enable;
   logic [2:0]  events;

   assign update_irq_enable   = control_reg[rtcio_pkg::BIT_UPDATE];
   assign periodic_irq_enable = control_reg[rtcio_pkg::BIT_PERIODIC];
   assign alarm_irq_enable    = control_reg[rtcio_pkg::BIT_ALARM];
   assign events = {i_update_event, i_periodic_event, i_alarm_event};

   // ****************************************************************
   // AXI4-Lite write path
   // ****************************************************************
   assign o_awready = !aw_held_reg && !bvalid_reg;
   assign o_wready  = !w_held_reg && !bvalid_reg;
   assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_lane0  = do_write && wstrb_reg[0];
   assign wr_flags  = wr_lane0 && (awaddr_reg == rtcio_pkg::ADDR_FLAGS);
   assign wr_control = wr_lane0 && (awaddr_reg == rtcio_pkg::ADDR_CONTROL);

   // Capture address and data in either order
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= i_awaddr;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= i_wdata;
            wstrb_reg  <= i_wstrb;
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Write response, unmapped address answers SLVERR
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= rtcio_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         unique case (awaddr_reg)
            rtcio_pkg::ADDR_FLAGS, rtcio_pkg::ADDR_CONTROL, rtcio_pkg::ADDR_IRQ_ST,
            rtcio_pkg::ADDR_IRQ_MSK, rtcio_pkg::ADDR_TEMP_W,
            rtcio_pkg::ADDR_BACKUP: bresp_reg <= rtcio_pkg::RESP_OKAY;
            default:                bresp_reg <= rtcio_pkg::RESP_SLVERR;
         endcase
      end else if (i_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign o_bvalid = bvalid_reg;
   assign o_bresp  = bresp_reg;

   // ****************************************************************
   // Control, backup and mask registers
   // ****************************************************************
   // Control: enables and clock reset bit, protected bits stay zero
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         control_reg <= rtcio_pkg::CONTROL_RST;
      end else if (wr_control) begin
         control_reg <= wdata_reg[7:0] & rtcio_pkg::CTRL_MASK;
      end else if (ce_prev_reg && !i_chip_enable) begin
         control_reg[rtcio_pkg::BIT_RESET] <= 1'b0;
      end
   end

   // Chip enable history for falling edge
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ce_prev_reg <= 1'b0;
      end else begin
         ce_prev_reg <= i_chip_enable;
      end
   end

   assign o_clock_hold = control_reg[rtcio_pkg::BIT_RESET];

   // Backup setup register, upper nibble forced to zero
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         backup_reg <= rtcio_pkg::BACKUP_RST;
      end else if (do_write && wstrb_reg[0] && (awaddr_reg == rtcio_pkg::ADDR_BACKUP)) begin
         backup_reg <= wdata_reg[7:0] & rtcio_pkg::BACKUP_MASK;
      end
   end

   assign o_supply_monitor_disable  = backup_reg[3];
   assign o_backflow_switch_disable = backup_reg[2];
   assign o_backup_sample_time      = backup_reg[1:0];

   // Mask register of status layout
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_mask_reg <= rtcio_pkg::MASK_RST;
      end else if (wr_lane0 && (awaddr_reg == rtcio_pkg::ADDR_IRQ_MSK)) begin
         irq_mask_reg <= wdata_reg[2:0];
      end
   end

   // Temperature refreshed on each compensation run
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         temp_reg <= 8'h00;
      end else if (i_temp_valid) begin
         temp_reg <= i_temp_data;
      end
   end

   // ****************************************************************
   // Event flags, set wins over clear
   // ****************************************************************
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         update_flag   <= 1'b0;
         periodic_flag <= 1'b0;
         alarm_flag    <= 1'b0;
      end else begin
         update_flag   <= i_update_event | (update_flag &
            !(wr_flags && !wdata_reg[rtcio_pkg::BIT_UPDATE]));
         periodic_flag <= i_periodic_event | (periodic_flag &
            !(wr_flags && !wdata_reg[rtcio_pkg::BIT_PERIODIC]));
         alarm_flag    <= i_alarm_event | (alarm_flag &
            !(wr_flags && !wdata_reg[rtcio_pkg::BIT_ALARM]));
      end
   end

   // Sticky status, cleared by a read, event wins
   assign rd_status = do_read && (i_araddr == rtcio_pkg::ADDR_IRQ_ST);
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_status_reg <= 3'h0;
      end else begin
         irq_status_reg <= events | (rd_status ? 3'h0 : irq_status_reg);
      end
   end

   assign o_irq = |(irq_status_reg & irq_mask_reg);

   // ****************************************************************
   // Gated sources and open-drain pin
   // ****************************************************************
   rtcio_pulse #(.AUTO_RELEASE(1'b1)) u_update (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_event   (i_update_event),
      .i_enable  (update_irq_enable),
      .i_flag    (update_flag),
      .o_active  (update_act)
   );

   rtcio_pulse #(.AUTO_RELEASE(1'b1)) u_periodic (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_event   (i_periodic_event),
      .i_enable  (periodic_irq_enable),
      .i_flag    (periodic_flag),
      .o_active  (periodic_act)
   );

   rtcio_pulse #(.AUTO_RELEASE(1'b0)) u_alarm (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_event   (i_alarm_event),
      .i_enable  (alarm_irq_enable),
      .i_flag    (alarm_flag | i_alarm_event),
      .o_active  (alarm_act)
   );

   assign o_int_oe  = update_act | periodic_act | alarm_act;
   assign o_int_out = 1'b0;

   // ****************************************************************
   // AXI4-Lite read path
   // ****************************************************************
   assign o_arready = !rvalid_reg;
   assign do_read   = i_arvalid && !rvalid_reg;

   // Read data mux, reserved bits zero
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= rtcio_pkg::RESP_OKAY;
      end else if (do_read) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= rtcio_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
         unique case (i_araddr)
            rtcio_pkg::ADDR_FLAGS: begin
               rdata_reg[5:3] <= {update_flag, periodic_flag, alarm_flag};
            end
            rtcio_pkg::ADDR_CONTROL: rdata_reg[7:0] <= control_reg;
            rtcio_pkg::ADDR_IRQ_ST:  rdata_reg[2:0] <= irq_status_reg;
            rtcio_pkg::ADDR_IRQ_MSK: rdata_reg[2:0] <= irq_mask_reg;
            rtcio_pkg::ADDR_TEMP_W:  rdata_reg[7:0] <= temp_reg;
            rtcio_pkg::ADDR_BACKUP:  rdata_reg[7:0] <= backup_reg;
            default:                 rresp_reg <= rtcio_pkg::RESP_SLVERR;
         endcase
      end else if (i_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign o_rvalid = rvalid_reg;
   assign o_rdata  = rdata_reg;
   assign o_rresp  = rresp_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_update_go;
      i_update_event && update_irq_enable && !wr_control;
   endsequence

   update_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      s_update_go |=> o_int_oe) else $error("update event did not drive pin");
   periodic_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_periodic_event && periodic_irq_enable && !wr_control |=> o_int_oe)
      else $error("periodic event did not drive pin");
   alarm_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_alarm_event && alarm_irq_enable && !wr_control |=> alarm_act)
      else $error("alarm not driven");
   enable_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !update_irq_enable |-> !update_act) else $error("disabled source drives");
   pin_or_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_int_oe == (update_act | periodic_act | alarm_act))
      else $error("pin not the OR of sources");
   alarm_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      alarm_act && alarm_flag && alarm_irq_enable && !wr_flags && !wr_control |=> alarm_act)
      else $error("alarm released early");
   flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      update_flag && !wr_flags |=> update_flag) else $error("flag lost");
   flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_alarm_event |=> alarm_flag) else $error("flag not set");
   backup_top_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      backup_reg[7:4] == 4'h0) else $error("backup upper bits set");
   reset_free_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      ce_prev_reg && !i_chip_enable && !wr_control |=> !o_clock_hold)
      else $error("clock reset not released");

endmodule : rtcio_top

// ### verification/rtcio_host_pin.sv
// Purpose: Host side of the open-drain interrupt pin
// Assumes: Board pull-up on the line
// Notes:   Pin reads high whenever the device lets go of it
`timescale 1ns/1ps
module rtcio_host_pin (
   input  wire logic i_int_out,
   input  wire logic i_int_oe,
   output logic      o_int_n
);
   // ****************************************************************
   // Wire level
   // ****************************************************************
   // Pull-up wins unless the device drives; never shows a stale value
   assign o_int_n = i_int_oe ? i_int_out : 1'b1;
endmodule : rtcio_host_pin

// ### verification/rtcio_bench.sv
// Purpose: Self-checking bench for the interrupt output block
// Assumes: AXI4-Lite tasks, host pin model with pull-up
// Notes:   7.8 ms auto release is too long to wait out; early release is checked
`timescale 1ns/1ps
module rtc_interrupt_output_control_bench;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, temp_data = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic [2:0]  ev = 3'h0;
   logic        chip_enable = 1'b1, temp_valid = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, clock_hold, smon_dis, bflow_dis;
   logic        int_out, int_oe, irq, int_n;
   logic [1:0]  bresp, rresp, sample_time, resp;
   logic [31:0] rdata, rd;
   int          bad_count = 0;
   int          checks_done = 0;

   // ****************************************************************
   // Clock, design and pin model
   // ****************************************************************
   always #4 clk_sys = ~clk_sys;

   rtcio_top rtcio_top_inst (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_update_event(ev[0]), .i_periodic_event(ev[1]), .i_alarm_event(ev[2]),
      .i_chip_enable(chip_enable), .i_temp_valid(temp_valid), .i_temp_data(temp_data),
      .o_clock_hold(clock_hold), .o_supply_monitor_disable(smon_dis),
      .o_backflow_switch_disable(bflow_dis), .o_backup_sample_time(sample_time),
      .o_int_out(int_out), .o_int_oe(int_oe), .o_irq(irq));

   rtcio_host_pin rtcio_host_pin_inst (.i_int_out(int_out), .i_int_oe(int_oe), .o_int_n(int_n));

   // ****************************************************************
   // Bus tasks and checks
   // ****************************************************************
   // Write: address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'h1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys);
         if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      while (!bvalid) @(posedge clk_sys);
      resp = bresp;
      bready <= 1'b0;
      #1;
   endtask : axi_write

   // Read: address held until taken, rready held until data comes
   task automatic axi_read(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk_sys);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      #1;
   endtask : axi_read

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : check

   // One-cycle event pulse, then time for the pin to follow
   task automatic pulse(input int k);
      @(posedge clk_sys);
      ev[k] <= 1'b1;
      @(posedge clk_sys);
      ev[k] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : pulse

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      summarize();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Reset values and write-protected bits
      axi_read(rtcio_pkg::ADDR_CONTROL); check(rd, 32'h0);
      axi_read(rtcio_pkg::ADDR_BACKUP); check(rd, 32'h0);
      axi_write(rtcio_pkg::ADDR_CONTROL, 32'hc6);
      axi_read(rtcio_pkg::ADDR_CONTROL); check(rd, 32'h0);
      axi_write(rtcio_pkg::ADDR_BACKUP, 32'hfa);
      axi_read(rtcio_pkg::ADDR_BACKUP); check(rd, 32'h0a);
      check({28'h0, smon_dis, bflow_dis, sample_time}, 32'ha);
      axi_write(rtcio_pkg::ADDR_BACKUP, 32'h05);
      check({28'h0, smon_dis, bflow_dis, sample_time}, 32'h5);
      $display("test registers done");
      // Enables off: flags set, pin left alone, flags polled
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         check({31'h0, int_n}, 32'h1);
      end
      axi_read(rtcio_pkg::ADDR_FLAGS); check(rd, 32'h38);
      axi_write(rtcio_pkg::ADDR_FLAGS, 32'h38);
      axi_read(rtcio_pkg::ADDR_FLAGS); check(rd, 32'h38);
      axi_write(rtcio_pkg::ADDR_FLAGS, 32'h00);
      axi_read(rtcio_pkg::ADDR_FLAGS); check(rd, 32'h00);
      $display("test polling done");
      // Each source with its enable pulls the pin low
      for (int k = 0; k < 3; k++) begin
         axi_write(rtcio_pkg::ADDR_CONTROL, 32'h1 << (5 - k));
         pulse(k);
         check({31'h0, int_n}, 32'h0);
         check({31'h0, int_oe}, 32'h1);
         axi_read(rtcio_pkg::ADDR_FLAGS); check(rd, 32'h1 << (5 - k));
         repeat (1000) @(posedge clk_sys);
         #1;
         check({31'h0, int_n}, 32'h0);
         axi_write(rtcio_pkg::ADDR_FLAGS, 32'h00);
         check({31'h0, int_n}, (k == 2) ? 32'h1 : 32'h0);
         axi_write(rtcio_pkg::ADDR_CONTROL, 32'h00);
         check({31'h0, int_n}, 32'h1);
      end
      // Two sources at once, one released, pin stays low
      axi_write(rtcio_pkg::ADDR_CONTROL, 32'h28);
      pulse(0);
      pulse(2);
      axi_write(rtcio_pkg::ADDR_FLAGS, 32'h00);
      check({31'h0, int_n}, 32'h0);
      axi_write(rtcio_pkg::ADDR_CONTROL, 32'h00);
      check({31'h0, int_n}, 32'h1);
      $display("test pin done");
      // Sticky status, mask and level interrupt
      axi_read(rtcio_pkg::ADDR_IRQ_ST);
      axi_write(rtcio_pkg::ADDR_IRQ_MSK, 32'h2);
      pulse(2);
      check({31'h0, irq}, 32'h0);
      pulse(1);
      check({31'h0, irq}, 32'h1);
      axi_read(rtcio_pkg::ADDR_IRQ_ST); check(rd, 32'h3);
      check({31'h0, irq}, 32'h0);
      axi_read(rtcio_pkg::ADDR_IRQ_ST); check(rd, 32'h0);
      $display("test irq done");
      // Clock reset held until chip enable goes low
      axi_write(rtcio_pkg::ADDR_CONTROL, 32'h01);
      check({31'h0, clock_hold}, 32'h1);
      repeat (5) @(posedge clk_sys);
      #1;
      check({31'h0, clock_hold}, 32'h1);
      @(posedge clk_sys);
      chip_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check({31'h0, clock_hold}, 32'h0);
      axi_read(rtcio_pkg::ADDR_CONTROL); check(rd, 32'h0);
      $display("test clock reset done");
      // Temperature reading in the low byte of its own word
      @(posedge clk_sys);
      temp_data <= 8'ha5; temp_valid <= 1'b1;
      @(posedge clk_sys);
      temp_valid <= 1'b0; temp_data <= 8'h5a;
      axi_read(rtcio_pkg::ADDR_TEMP_W); check(rd, 32'ha5);
      // Unmapped address
      axi_read(8'h40); check({30'h0, resp}, {30'h0, rtcio_pkg::RESP_SLVERR});
      axi_write(8'h40, 32'h1); check({30'h0, resp}, {30'h0, rtcio_pkg::RESP_SLVERR});
      $display("test temperature and decode done");
      summarize();
   end
endmodule : rtc_interrupt_output_control_bench
